// [lpbpc_cfg.svh]
`ifndef LPBPC_CFG_SVH
`define LPBPC_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define LPBPC_IDX_LOCAL_HIGH   10'h204
`define LPBPC_IDX_LOW          10'h205
`define LPBPC_IDX_MID          10'h206
`define LPBPC_IDX_HIGH         10'h207
`define LPBPC_MMD_ADDR         5'h07

// reset values
`define LPBPC_RST_WORD         16'h0000
`define LPBPC_RST_LOCAL        1'b0

// stored and readable bits of each word; only the local bits are writable
`define LPBPC_MID_MASK         16'h40f0
`define LPBPC_HIGH_MASK        16'h7800
`define LPBPC_LOW_MASK         16'hfc1f
`define LPBPC_LOCAL_MASK       16'h3000

// mid word fields
`define LPBPC_MID_LONG_REACH   14
`define LPBPC_MID_GIGABIT      7
`define LPBPC_MID_SR_FULL      6
`define LPBPC_MID_FAST         5
`define LPBPC_MID_LEADER       4

// high word fields
`define LPBPC_HIGH_ENERGY      14
`define LPBPC_HIGH_SWING_ABLE  13
`define LPBPC_HIGH_SWING_REQ   12
`define LPBPC_HIGH_SR_HALF     11

// low word fields
`define LPBPC_LOW_ROLE_FORCED  12

// local advertisement word fields, same positions as the partner's
`define LPBPC_LOCAL_SWING_ABLE 13
`define LPBPC_LOCAL_SWING_REQ  12

`endif

// [lpbpc_pkg.sv]
package lpbpc_pkg;

   typedef struct packed {
      logic [15:0] liveLow;
      logic [15:0] liveMid;
      logic [15:0] liveHigh;
      logic [15:0] capMid;
      logic [15:0] capHigh;
      logic        localSwingAble;
      logic        localSwingRequest;
      logic        txLevelHigh;
      logic [31:0] prdata;
      logic        pslverr;
   } lpbpc_state_t;

endpackage

// [lpbpc_capture.sv]
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "lpbpc_cfg.svh"

module lpbpc_capture (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // from the negotiation engine
   input  wire logic        basePageValid,
   input  wire logic [47:0] basePage,
   input  wire logic        anRestart,
   // decoded partner abilities, held copy except partnerRoleForced, which follows the live low word
   output logic             partnerLongReachAble,
   output logic             partnerGigabitAble,
   output logic             partnerShortReachFullDuplexAble,
   output logic             partnerFastAble,
   output logic             partnerLeaderSelect,
   output logic             partnerRoleForced,
   output logic             partnerEnergySavingAble,
   output logic             partnerHighSwingAble,
   output logic             partnerHighSwingRequest,
   output logic             partnerShortReachHalfDuplexAble,
   // resolved transmit level: 1 = 2.4 V p-p, 0 = 1.0 V p-p
   output logic             txLevelHigh
);

   lpbpc_pkg::lpbpc_state_t stateReg;
   lpbpc_pkg::lpbpc_state_t stateNext;

   logic setupPhase;
   logic accessPhase;

   function automatic logic regHit(input logic [11:0] addr, input logic [9:0] index);
      regHit = (addr == {index, 2'b00});
   endfunction

   function automatic logic resolveHigh(input logic ableA, input logic reqA,
                                        input logic ableB, input logic reqB);
      resolveHigh = ableA && ableB && (reqA || reqB);
   endfunction

   assign setupPhase  = psel && !penable;
   assign accessPhase = psel && penable;

   always_comb begin
      stateNext = stateReg;

      // a page that lands with a restart wins, so no received page is lost
      if (basePageValid) begin
         stateNext.liveLow  = basePage[15:0] & `LPBPC_LOW_MASK;
         stateNext.liveMid  = basePage[31:16] & `LPBPC_MID_MASK;
         stateNext.liveHigh = basePage[47:32] & `LPBPC_HIGH_MASK;
      end else if (anRestart) begin
         stateNext.liveLow  = `LPBPC_RST_WORD;
         stateNext.liveMid  = `LPBPC_RST_WORD;
         stateNext.liveHigh = `LPBPC_RST_WORD;
      end

      // read data is built in the setup cycle so prdata comes from a flop
      if (setupPhase) begin
         stateNext.pslverr = 1'b0;
         stateNext.prdata  = 32'h0000_0000;
         if (regHit(paddr, `LPBPC_IDX_LOW)) begin
            stateNext.prdata = {16'h0000, stateReg.liveLow};
         end else if (regHit(paddr, `LPBPC_IDX_MID)) begin
            stateNext.prdata = {16'h0000, stateReg.capMid};
         end else if (regHit(paddr, `LPBPC_IDX_HIGH)) begin
            stateNext.prdata = {16'h0000, stateReg.capHigh};
         end else if (regHit(paddr, `LPBPC_IDX_LOCAL_HIGH)) begin
            stateNext.prdata[`LPBPC_LOCAL_SWING_ABLE] = stateReg.localSwingAble;
            stateNext.prdata[`LPBPC_LOCAL_SWING_REQ]  = stateReg.localSwingRequest;
         end else begin
            stateNext.pslverr = 1'b1;
         end
      end

      // the snapshot is taken at the completing edge of the low-word read
      if (accessPhase && !pwrite && regHit(paddr, `LPBPC_IDX_LOW)) begin
         stateNext.capMid  = stateReg.liveMid;
         stateNext.capHigh = stateReg.liveHigh;
      end

      // partner words are read-only; only the local advertisement bits take writes
      if (accessPhase && pwrite && regHit(paddr, `LPBPC_IDX_LOCAL_HIGH) && pstrb[1]) begin
         stateNext.localSwingAble    = pwdata[`LPBPC_LOCAL_SWING_ABLE];
         stateNext.localSwingRequest = pwdata[`LPBPC_LOCAL_SWING_REQ];
      end

      // resolved from live values: the level must follow the link, not software reads
      stateNext.txLevelHigh = resolveHigh(stateReg.localSwingAble,
                                          stateReg.localSwingRequest,
                                          stateReg.liveHigh[`LPBPC_HIGH_SWING_ABLE],
                                          stateReg.liveHigh[`LPBPC_HIGH_SWING_REQ]);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stateReg.liveLow           <= `LPBPC_RST_WORD;
         stateReg.liveMid           <= `LPBPC_RST_WORD;
         stateReg.liveHigh          <= `LPBPC_RST_WORD;
         stateReg.capMid            <= `LPBPC_RST_WORD;
         stateReg.capHigh           <= `LPBPC_RST_WORD;
         stateReg.localSwingAble    <= `LPBPC_RST_LOCAL;
         stateReg.localSwingRequest <= `LPBPC_RST_LOCAL;
         stateReg.txLevelHigh       <= 1'b0;
         stateReg.prdata            <= 32'h0000_0000;
         stateReg.pslverr           <= 1'b0;
      end else begin
         stateReg <= stateNext;
      end
   end

   // zero-wait slave: every access phase completes in its first cycle
   assign pready  = accessPhase;
   assign prdata  = stateReg.prdata;
   assign pslverr = accessPhase && stateReg.pslverr;

   assign partnerLongReachAble            = stateReg.capMid[`LPBPC_MID_LONG_REACH];
   assign partnerGigabitAble              = stateReg.capMid[`LPBPC_MID_GIGABIT];
   assign partnerShortReachFullDuplexAble = stateReg.capMid[`LPBPC_MID_SR_FULL];
   assign partnerFastAble                 = stateReg.capMid[`LPBPC_MID_FAST];
   assign partnerLeaderSelect             = stateReg.capMid[`LPBPC_MID_LEADER];
   assign partnerRoleForced               = stateReg.liveLow[`LPBPC_LOW_ROLE_FORCED];
   assign partnerEnergySavingAble         = stateReg.capHigh[`LPBPC_HIGH_ENERGY];
   assign partnerHighSwingAble            = stateReg.capHigh[`LPBPC_HIGH_SWING_ABLE];
   assign partnerHighSwingRequest         = stateReg.capHigh[`LPBPC_HIGH_SWING_REQ];
   assign partnerShortReachHalfDuplexAble = stateReg.capHigh[`LPBPC_HIGH_SR_HALF];
   assign txLevelHigh                     = stateReg.txLevelHigh;

endmodule

// [lpbpc_capture_chk.sv]
`timescale 1ns/1ps

module lpbpc_capture_chk (
   // apb
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // held abilities
   input wire logic        partnerLongReachAble,
   input wire logic        partnerGigabitAble,
   input wire logic        partnerShortReachFullDuplexAble,
   input wire logic        partnerFastAble,
   input wire logic        partnerLeaderSelect,
   input wire logic        partnerEnergySavingAble,
   input wire logic        partnerHighSwingAble,
   input wire logic        partnerHighSwingRequest,
   input wire logic        partnerShortReachHalfDuplexAble
);
   wire logic [15:0] hMid = {1'b0, partnerLongReachAble, 6'h0, partnerGigabitAble,
      partnerShortReachFullDuplexAble, partnerFastAble, partnerLeaderSelect, 4'h0};
   wire logic [15:0] hHigh = {1'b0, partnerEnergySavingAble, partnerHighSwingAble,
      partnerHighSwingRequest, partnerShortReachHalfDuplexAble, 11'h0};
   wire logic        rd = psel && penable && !pwrite;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   property p_hold; !(rd && paddr == 12'h814) |=> $stable({hMid, hHigh}); endproperty
   a_hold: assert property (p_hold) else $error("held copy moved");
   property p_mid; rd && paddr == 12'h818 |-> prdata == {16'h0, hMid} && !pslverr; endproperty
   a_mid: assert property (p_mid) else $error("mid read wrong");
   property p_high; rd && paddr == 12'h81c |-> prdata == {16'h0, hHigh}; endproperty
   a_high: assert property (p_high) else $error("high read wrong");
   property p_rdy; psel && !penable ##1 psel && penable |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_idle; !(psel && penable) |-> !pready && !pslverr; endproperty
   a_idle: assert property (p_idle) else $error("ready outside access");
   property p_err; rd && !(paddr inside {[12'h810:12'h81c]}) |-> pslverr && prdata == 0; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   // only the mid and high words: other addresses with bit 3 set are unmapped and refused
   property p_wr;
      psel && penable && pwrite && paddr inside {12'h818, 12'h81c} |-> !pslverr ##1 $stable(hMid);
   endproperty
   a_wr: assert property (p_wr) else $error("read-only word written");
   property p_rst; $fell(rst) |-> hMid == 16'h0 && hHigh == 16'h0; endproperty
   a_rst: assert property (p_rst) else $error("reset value wrong");
   c_low: cover property (rd && paddr == 12'h814);
   c_mid: cover property (rd && paddr == 12'h818 && hMid != 16'h0);
   c_err: cover property (rd && pslverr);
endmodule

bind lpbpc_capture lpbpc_capture_chk u_chk (.*);

// [lp_base_page_ability_capture_bench.sv]
`timescale 1ns/1ps

module lp_base_page_ability_capture_bench;
   logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        basePageValid = 1'b0, anRestart = 1'b0, pready, pslverr, txLevelHigh;
   logic        roleForced;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [47:0] basePage = 48'h0, pg;
   logic [32:0] expQ[$];
   int          err_count = 0, n_checks = 0;

   lpbpc_capture u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .basePageValid(basePageValid),
      .basePage(basePage), .anRestart(anRestart), .partnerLongReachAble(),
      .partnerGigabitAble(), .partnerShortReachFullDuplexAble(), .partnerFastAble(),
      .partnerLeaderSelect(), .partnerRoleForced(roleForced), .partnerEnergySavingAble(),
      .partnerHighSwingAble(), .partnerHighSwingRequest(),
      .partnerShortReachHalfDuplexAble(), .txLevelHigh(txLevelHigh));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // psel stays up after the access so that a following setup may come at once
   task automatic apb(input logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
      int k;
      if (!w)
         expQ.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_sys);
         if (pready === 1'b1)
            break;
      end
      penable <= 1'b0;
      if (k == 20) begin
         err_count++;
         tally_and_finish();
      end
   endtask
   task automatic page(input logic [47:0] p, input logic clr);
      psel <= 1'b0;
      basePageValid <= !clr;
      anRestart <= clr;
      basePage <= p;
      @(posedge clk_sys);
      basePageValid <= 1'b0;
      anRestart <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   always @(posedge clk_sys) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         cmp({pslverr, prdata}, expQ.pop_front());
   end
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      void'($urandom(32'hf18b67dd));
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      apb(0, 12'h818, 0, 33'h0);
      apb(0, 12'h81c, 0, 33'h0);
      apb(0, 12'h820, 0, {1'b1, 32'h0});
      pg = 48'({$urandom, $urandom});
      page(pg, 0);
      cmp({32'h0, roleForced}, {32'h0, pg[12]});
      apb(0, 12'h818, 0, 33'h0);
      apb(0, 12'h814, 0, {17'h0, pg[15:0] & 16'hfc1f});
      apb(0, 12'h818, 0, {17'h0, pg[31:16] & 16'h40f0});
      apb(0, 12'h81c, 0, {17'h0, pg[47:32] & 16'h7800});
      apb(1, 12'h818, 32'hffff, 0);
      page(~pg, 0);
      apb(0, 12'h818, 0, {17'h0, pg[31:16] & 16'h40f0});
      page(pg, 1);
      cmp({32'h0, roleForced}, 33'h0);
      apb(0, 12'h814, 0, 33'h0);
      apb(0, 12'h81c, 0, 33'h0);
      for (int i = 0; i < 16; i++) begin
         apb(1, 12'h810, {18'h0, i[3:2], 12'h0}, 0);
         apb(0, 12'h810, 0, {19'h0, i[3:2], 12'h0});
         page({2'h0, i[1:0], 44'h0}, 0);
         cmp({32'h0, txLevelHigh}, {32'h0, i[3] & i[1] & (i[2] | i[0])});
      end
      tally_and_finish();
   end
endmodule
